/* File: hw/telemetry_bank.sv */
// Status and telemetry register bank with peak hold and paging.
`timescale 1ns/1ps
`default_nettype none
module telemetry_bank #(
    parameter int NCH = 2
) (
    input  wire logic                           CLK_SYS,
    input  wire logic                           RST_N,
    input  wire telemetry_bank_pkg::host_req_t  HOST_REQ,
    input  wire logic                           MEAS_VALID,
    input  wire logic [15:0]                    MEAS_VIN,
    input  wire logic [15:0]                    MEAS_IOUT,
    input  wire logic [15:0]                    MEAS_TDIE,
    input  wire logic [15:0]                    MEAS_FREQ,
    input  wire logic [15:0]                    MEAS_POUT,
    input  wire telemetry_bank_pkg::chan_meas_t MEAS_CH [NCH],
    input  wire telemetry_bank_pkg::dev_flags_t DEV_FLAGS,
    input  wire logic                           STARTUP_DONE,
    input  wire logic                           ADC_CUR_BUSY,
    input  wire logic                           ECC_CORRECTED,
    input  wire logic                           NVM_BULK_READ,
    output logic [15:0]                         RD_DATA,
    output logic                                RD_VALID,
    output logic                                ALERT_EVT,
    output logic [7:0]                          ADC_SEL,
    output logic [15:0]                         STATUS_WORD_HI,
    output logic                                PEAK_CLEARED
);
    import telemetry_bank_pkg::*;

    // -------------------------------------------------------------------------
    // Input synchronisers for asynchronous pin levels
    // -------------------------------------------------------------------------
    logic [15:0] pins_s1_r;
    logic [15:0] pins_s2_r;
    logic [7:0]  comm_s1_r;
    logic [7:0]  comm_s2_r;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pins_s1_r <= 16'h0000;
            pins_s2_r <= 16'h0000;
            comm_s1_r <= 8'h00;
            comm_s2_r <= 8'h00;
        end else begin
            pins_s1_r <= DEV_FLAGS.pins;
            pins_s2_r <= pins_s1_r;
            comm_s1_r <= DEV_FLAGS.common;
            comm_s2_r <= comm_s1_r;
        end
    end

    // -------------------------------------------------------------------------
    // Command decode
    // -------------------------------------------------------------------------
    logic wr_page;
    logic wr_cml;
    logic wr_vnd;
    logic wr_sel;
    logic clr_all;
    logic clr_peaks;
    logic flog_erase;
    logic ecc_refresh;
    logic sel_reserved;

    assign wr_page     = HOST_REQ.wr && HOST_REQ.code == CMD_PAGE;
    assign wr_cml      = HOST_REQ.wr && HOST_REQ.code == CMD_CML_STATUS;
    assign wr_vnd      = HOST_REQ.wr && HOST_REQ.code == CMD_VENDOR_STAT;
    assign wr_sel      = HOST_REQ.wr && HOST_REQ.code == CMD_ADC_SEL;
    assign clr_all     = HOST_REQ.wr && HOST_REQ.code == CMD_CLEAR_FLT;
    assign clr_peaks   = HOST_REQ.wr && (HOST_REQ.code == CMD_PEAK_CLR
                                      || HOST_REQ.code == CMD_DEV_RESET);
    assign flog_erase  = HOST_REQ.wr && HOST_REQ.code == CMD_FLOG_ERASE;
    assign ecc_refresh = NVM_BULK_READ || (HOST_REQ.wr && (HOST_REQ.code == CMD_RESTORE
                                      || HOST_REQ.code == CMD_DEV_RESET));

    // -------------------------------------------------------------------------
    // Page pointer and fast ADC selector
    // -------------------------------------------------------------------------
    logic       page_r;
    logic [7:0] adc_sel_r;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            page_r <= 1'b0;
        end else if (wr_page) begin
            page_r <= HOST_REQ.data[0];
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            adc_sel_r <= ADC_SEL_RST;
        end else if (wr_sel) begin
            adc_sel_r <= HOST_REQ.data[7:0];
        end
    end

    // Upper selector values and holes in the table are reserved.
    assign sel_reserved = (adc_sel_r[7:4] != 4'h0) || !ADC_SEL_VALID[adc_sel_r[3:0]];

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ADC_SEL <= 8'h00;
        end else begin
            ADC_SEL <= sel_reserved ? 8'h04 : adc_sel_r;
        end
    end

    // -------------------------------------------------------------------------
    // Command fault status byte (write one to clear, set wins)
    // -------------------------------------------------------------------------
    logic [7:0] cml_r;
    logic [7:0] cml_set;
    logic [7:0] cml_nxt;
    logic       inv_read;

    assign inv_read = HOST_REQ.rd && sel_reserved && HOST_REQ.code == CMD_ADC_SEL;

    always_comb begin
        cml_set = DEV_FLAGS.cml_evt;
        cml_set[CML_OTHER_LOGIC] = cml_set[CML_OTHER_LOGIC] | sel_reserved;
        cml_set[CML_INV_CMD_BIT] = cml_set[CML_INV_CMD_BIT] | inv_read;
        cml_set = cml_set & CML_VALID_MASK;
        cml_nxt = cml_r;
        if (wr_cml) begin
            cml_nxt = cml_nxt & ~HOST_REQ.data[7:0];
        end
        if (clr_all) begin
            cml_nxt = 8'h00;
        end
        cml_nxt = cml_nxt | cml_set;
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            cml_r <= 8'h00;
        end else begin
            cml_r <= cml_nxt;
        end
    end

    // -------------------------------------------------------------------------
    // Vendor status byte; fault log flag ignores write-one-clear
    // -------------------------------------------------------------------------
    logic [7:0] vnd_r;
    logic [7:0] vnd_nxt;
    logic [7:0] vnd_clr;

    always_comb begin
        vnd_clr = 8'h00;
        if (wr_vnd) begin
            vnd_clr = HOST_REQ.data[7:0];
        end
        if (clr_all) begin
            vnd_clr = 8'hff;
        end
        vnd_clr[VND_FLOG_BIT] = flog_erase;
        vnd_nxt = ((vnd_r & ~vnd_clr) | DEV_FLAGS.vnd_evt) & VND_VALID_MASK;
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            vnd_r <= 8'h00;
        end else begin
            vnd_r <= vnd_nxt;
        end
    end

    // -------------------------------------------------------------------------
    // Alert event and status word summary
    // -------------------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ALERT_EVT <= 1'b0;
        end else begin
            ALERT_EVT <= |(cml_nxt & ~cml_r) || |(vnd_nxt & ~vnd_r);
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            STATUS_WORD_HI <= 16'h0000;
        end else begin
            STATUS_WORD_HI <= 16'h0000;
            STATUS_WORD_HI[SW_VENDOR_BIT] <= |vnd_nxt;
        end
    end

    // -------------------------------------------------------------------------
    // Memory ECC information
    // -------------------------------------------------------------------------
    logic ecc_clean_r;
    logic booted_r;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ecc_clean_r <= 1'b1;
            booted_r    <= 1'b0;
        end else begin
            booted_r <= 1'b1;
            if (ecc_refresh || !booted_r) begin
                ecc_clean_r <= !ECC_CORRECTED;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Peak-hold registers
    // -------------------------------------------------------------------------
    logic [15:0] pk_iout_r;
    logic [15:0] pk_vin_r;
    logic [15:0] pk_tdie_r;
    logic [15:0] pk_vout_r [NCH];
    logic [15:0] pk_iin_r  [NCH];
    logic [15:0] pk_text_r [NCH];

    // Compares two values in exponent-mantissa form by their signed value.
    function automatic logic l11_gt(input logic [15:0] a, input logic [15:0] b);
        logic signed [4:0]  ea;
        logic signed [4:0]  eb;
        logic signed [42:0] va;
        logic signed [42:0] vb;
        ea = a[15:11];
        eb = b[15:11];
        va = 43'(signed'(a[10:0])) <<< (ea + 5'sd16);
        vb = 43'(signed'(b[10:0])) <<< (eb + 5'sd16);
        return va > vb;
    endfunction : l11_gt

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pk_iout_r <= PEAK_RST;
            pk_vin_r  <= PEAK_RST;
            pk_tdie_r <= PEAK_RST;
        end else if (clr_peaks) begin
            pk_iout_r <= PEAK_RST;
            pk_vin_r  <= PEAK_RST;
            pk_tdie_r <= PEAK_RST;
        end else if (MEAS_VALID) begin
            if (l11_gt(MEAS_IOUT, pk_iout_r)) pk_iout_r <= MEAS_IOUT;
            if (l11_gt(MEAS_VIN, pk_vin_r))   pk_vin_r  <= MEAS_VIN;
            if (l11_gt(MEAS_TDIE, pk_tdie_r)) pk_tdie_r <= MEAS_TDIE;
        end
    end

    generate
        for (genvar ch = 0; ch < NCH; ch++) begin : g_peak
            always_ff @(posedge CLK_SYS or negedge RST_N) begin
                if (!RST_N) begin
                    pk_vout_r[ch] <= L16_PEAK_RST;
                    pk_iin_r[ch]  <= PEAK_RST;
                    pk_text_r[ch] <= PEAK_RST;
                end else if (clr_peaks) begin
                    pk_vout_r[ch] <= L16_PEAK_RST;
                    pk_iin_r[ch]  <= PEAK_RST;
                    pk_text_r[ch] <= PEAK_RST;
                end else if (MEAS_VALID) begin
                    if (MEAS_CH[ch].vout > pk_vout_r[ch]) pk_vout_r[ch] <= MEAS_CH[ch].vout;
                    if (l11_gt(MEAS_CH[ch].iin, pk_iin_r[ch])) pk_iin_r[ch] <= MEAS_CH[ch].iin;
                    if (l11_gt(MEAS_CH[ch].text, pk_text_r[ch])) pk_text_r[ch] <= MEAS_CH[ch].text;
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            PEAK_CLEARED <= 1'b0;
        end else begin
            PEAK_CLEARED <= clr_peaks;
        end
    end

    // -------------------------------------------------------------------------
    // Pin state word
    // -------------------------------------------------------------------------
    logic [15:0] pin_word;

    always_comb begin
        pin_word = pins_s2_r;
        pin_word[13:12] = 2'b00;
        pin_word[11] = !STARTUP_DONE || ADC_CUR_BUSY;
    end

    // -------------------------------------------------------------------------
    // Read multiplexer
    // -------------------------------------------------------------------------
    chan_meas_t  cur;
    logic [15:0] rd_nxt;

    assign cur = MEAS_CH[page_r];

    always_comb begin
        case (HOST_REQ.code)
            CMD_PAGE:        rd_nxt = {15'h0000, page_r};
            CMD_STATUS_WORD: rd_nxt = {3'b000, |vnd_r, 12'h000};
            CMD_CML_STATUS:  rd_nxt = {8'h00, cml_r};
            CMD_VENDOR_STAT: rd_nxt = {8'h00, vnd_r};
            CMD_VIN:         rd_nxt = MEAS_VIN;
            CMD_IIN:         rd_nxt = cur.iin;
            CMD_VOUT:        rd_nxt = cur.vout;
            CMD_IOUT:        rd_nxt = MEAS_IOUT;
            CMD_TEMP_EXT:    rd_nxt = cur.text;
            CMD_TEMP_DIE:    rd_nxt = MEAS_TDIE;
            CMD_FREQ:        rd_nxt = MEAS_FREQ;
            CMD_POUT:        rd_nxt = MEAS_POUT;
            CMD_PIN_PWR:     rd_nxt = cur.pin;
            CMD_IOUT_PK:     rd_nxt = pk_iout_r;
            CMD_ADC_SEL:     rd_nxt = {8'h00, adc_sel_r};
            CMD_VOUT_PK:     rd_nxt = pk_vout_r[page_r];
            CMD_VIN_PK:      rd_nxt = pk_vin_r;
            CMD_TEXT_PK:     rd_nxt = pk_text_r[page_r];
            CMD_IIN_PK:      rd_nxt = pk_iin_r[page_r];
            CMD_TDIE_PK:     rd_nxt = pk_tdie_r;
            CMD_PINS:        rd_nxt = pin_word;
            CMD_COMMON:      rd_nxt = {8'h00, comm_s2_r[7:3], 1'b0, comm_s2_r[1:0]};
            CMD_MEM_INFO:    rd_nxt = {10'h000, ecc_clean_r, 5'h00};
            default:         rd_nxt = 16'h0000;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            RD_DATA  <= 16'h0000;
            RD_VALID <= 1'b0;
        end else begin
            RD_VALID <= HOST_REQ.rd;
            if (HOST_REQ.rd) begin
                RD_DATA <= rd_nxt;
            end
        end
    end

endmodule : telemetry_bank
`default_nettype wire

/* File: hw/telemetry_bank_pkg.sv */
// Package of constants and types for the status and telemetry register bank.
//
// Functional notes
// - Command status byte flags seven communication faults.
// - Writing one clears only that command flag.
// - New command status flag raises alert event.
// - Vendor status byte reports seven internal conditions.
// - Any vendor flag sets status word bit.
// - Vendor flags write-one-clear; fault log needs erase.
// - Pin state word reports supply, pins, good.
// - ADC invalid flag asserted through start-up.
// - Pin bits true-high, two bytes, read-only.
// - Common status byte reports readiness and pins.
// - Memory info bit 5 low means corrections.
// - ECC status refreshed on restore, reset, bulk.
// - Code 0x88 input voltage, 0x89 paged current.
// - Code 0x8d paged external diode temperature.
// - Code 0x8e die temperature only reported.
// - Code 0xd7 output current peak, non-paged.
// - Code 0xdd paged output voltage peak, unsigned.
// - Code 0xde input voltage peak, non-paged.
// - Codes 0xe1, 0xdf paged current, temperature peaks.
// - Code 0xf4 die temperature peak, non-paged.
// - Code 0xd8 fast ADC selector, resets zero.
// - Input voltage read-only, exponent-mantissa two bytes.
// - Peak clear or device reset clears peaks.
// - Reserved selector uses die temperature, faults.
// - Status word bit 12 flags vendor fault.
package telemetry_bank_pkg;

    // -------------------------------------------------------------------------
    // Command codes
    // -------------------------------------------------------------------------
    localparam logic [7:0] CMD_PAGE        = 8'h00;
    localparam logic [7:0] CMD_CLEAR_FLT   = 8'h03;
    localparam logic [7:0] CMD_RESTORE     = 8'h16;
    localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
    localparam logic [7:0] CMD_CML_STATUS  = 8'h7e;
    localparam logic [7:0] CMD_VENDOR_STAT = 8'h80;
    localparam logic [7:0] CMD_VIN         = 8'h88;
    localparam logic [7:0] CMD_IIN         = 8'h89;
    localparam logic [7:0] CMD_VOUT        = 8'h8b;
    localparam logic [7:0] CMD_IOUT        = 8'h8c;
    localparam logic [7:0] CMD_TEMP_EXT    = 8'h8d;
    localparam logic [7:0] CMD_TEMP_DIE    = 8'h8e;
    localparam logic [7:0] CMD_FREQ        = 8'h95;
    localparam logic [7:0] CMD_POUT        = 8'h96;
    localparam logic [7:0] CMD_PIN_PWR     = 8'h97;
    localparam logic [7:0] CMD_IOUT_PK     = 8'hd7;
    localparam logic [7:0] CMD_ADC_SEL     = 8'hd8;
    localparam logic [7:0] CMD_VOUT_PK     = 8'hdd;
    localparam logic [7:0] CMD_VIN_PK      = 8'hde;
    localparam logic [7:0] CMD_TEXT_PK     = 8'hdf;
    localparam logic [7:0] CMD_IIN_PK      = 8'he1;
    localparam logic [7:0] CMD_PEAK_CLR    = 8'he3;
    localparam logic [7:0] CMD_PINS        = 8'he5;
    localparam logic [7:0] CMD_COMMON      = 8'hef;
    localparam logic [7:0] CMD_FLOG_ERASE  = 8'hec;
    localparam logic [7:0] CMD_DEV_RESET   = 8'hfd;
    localparam logic [7:0] CMD_MEM_INFO    = 8'hb6;
    localparam logic [7:0] CMD_TDIE_PK     = 8'hf4;

    // -------------------------------------------------------------------------
    // Field positions and reset values
    // -------------------------------------------------------------------------
    localparam int          CML_RSVD_BIT     = 2;
    localparam logic [7:0]  CML_VALID_MASK   = 8'hfb;
    localparam int          CML_INV_CMD_BIT  = 7;
    localparam int          CML_OTHER_LOGIC  = 0;
    localparam int          VND_FLOG_BIT     = 3;
    localparam logic [7:0]  VND_VALID_MASK   = 8'hfd;
    localparam int          SW_VENDOR_BIT    = 12;
    localparam int          ECC_BIT          = 5;
    localparam logic [7:0]  ADC_SEL_RST      = 8'h00;
    localparam logic [15:0] ADC_SEL_VALID    = 16'h177b;
    localparam logic [15:0] PEAK_RST         = 16'h0000;
    localparam logic [15:0] L16_PEAK_RST     = 16'h0000;

    // Host-side command strobe with its data word.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  code;
        logic [15:0] data;
    } host_req_t;

    // Per-channel measurements, all in transfer format.
    typedef struct packed {
        logic [15:0] iin;
        logic [15:0] vout;
        logic [15:0] text;
        logic [15:0] pin;
    } chan_meas_t;

    // Flag events and levels reported by the rest of the device.
    typedef struct packed {
        logic [7:0]  cml_evt;
        logic [7:0]  vnd_evt;
        logic [15:0] pins;
        logic [7:0]  common;
    } dev_flags_t;

endpackage : telemetry_bank_pkg

/* File: dv/telemetry_bank_monitor.sv */
// Port checker for the status and telemetry register bank.
`timescale 1ns/1ps
`default_nettype none
module telemetry_bank_monitor (
    input wire logic                           CLK_SYS,
    input wire logic                           RST_N,
    input wire telemetry_bank_pkg::host_req_t  HOST_REQ,
    input wire logic [15:0]                    MEAS_VIN,
    input wire logic [15:0]                    MEAS_TDIE,
    input wire telemetry_bank_pkg::dev_flags_t DEV_FLAGS,
    input wire logic [15:0]                    RD_DATA,
    input wire logic                           RD_VALID,
    input wire logic [7:0]                     ADC_SEL,
    input wire logic [15:0]                    STATUS_WORD_HI,
    input wire logic                           PEAK_CLEARED
);
    import telemetry_bank_pkg::*;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    property p_rd_ans; HOST_REQ.rd |=> RD_VALID; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_rd_idle; !HOST_REQ.rd |=> !RD_VALID && $stable(RD_DATA); endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("answer without read");
    property p_vin; HOST_REQ.rd && HOST_REQ.code == CMD_VIN |=> RD_DATA == $past(MEAS_VIN); endproperty
    a_vin: assert property (p_vin) else $error("input voltage read wrong");
    property p_tdie; HOST_REQ.rd && HOST_REQ.code == CMD_TEMP_DIE |=> RD_DATA == $past(MEAS_TDIE); endproperty
    a_tdie: assert property (p_tdie) else $error("die temperature read wrong");
    property p_sel; ADC_SEL[7:4] == 4'h0 && ADC_SEL_VALID[ADC_SEL[3:0]]; endproperty
    a_sel: assert property (p_sel) else $error("selector shows reserved value");
    property p_vsum; (DEV_FLAGS.vnd_evt & VND_VALID_MASK) != 8'h00 |-> ##[1:2] STATUS_WORD_HI[12]; endproperty
    a_vsum: assert property (p_vsum) else $error("vendor summary bit missing");
    property p_swz; STATUS_WORD_HI[15:13] == 3'h0 && STATUS_WORD_HI[11:0] == 12'h000; endproperty
    a_swz: assert property (p_swz) else $error("status word stray bits");
    property p_pclr;
        HOST_REQ.wr && (HOST_REQ.code == CMD_PEAK_CLR || HOST_REQ.code == CMD_DEV_RESET) |-> ##[1:2] PEAK_CLEARED;
    endproperty
    a_pclr: assert property (p_pclr) else $error("peak clear not done");
    property p_info; HOST_REQ.rd && HOST_REQ.code == CMD_MEM_INFO |=> RD_DATA[15:6] == 10'h0 && RD_DATA[4:0] == 5'h0; endproperty
    a_info: assert property (p_info) else $error("memory info reserved bits set");
    property p_cml; HOST_REQ.rd && HOST_REQ.code == CMD_CML_STATUS |=> RD_DATA[15:8] == 8'h00 && !RD_DATA[2]; endproperty
    a_cml: assert property (p_cml) else $error("command status reserved bits set");
endmodule : telemetry_bank_monitor
bind telemetry_bank telemetry_bank_monitor i_mon (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .HOST_REQ(HOST_REQ),
    .MEAS_VIN(MEAS_VIN), .MEAS_TDIE(MEAS_TDIE), .DEV_FLAGS(DEV_FLAGS), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
    .ADC_SEL(ADC_SEL), .STATUS_WORD_HI(STATUS_WORD_HI), .PEAK_CLEARED(PEAK_CLEARED));
`default_nettype wire

/* File: dv/host_model.sv */
// Host model that sends command strobes and collects read answers.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic                          CLK_SYS,
    output var telemetry_bank_pkg::host_req_t  HOST_REQ,
    input  wire logic [15:0]                   RD_DATA,
    input  wire logic                          RD_VALID
);
    import telemetry_bank_pkg::*;
    logic fatal_seen;
    initial begin
        HOST_REQ = '0;
        fatal_seen = 1'b0;
    end
    task automatic send(input logic [7:0] code, input logic [15:0] data);
        @(negedge CLK_SYS);
        HOST_REQ = '{wr: 1'b1, rd: 1'b0, code: code, data: data};
        @(negedge CLK_SYS);
        HOST_REQ = '0;
    endtask : send
    task automatic get(input logic [7:0] code, output logic ok, output logic [15:0] d);
        @(negedge CLK_SYS);
        HOST_REQ = '{wr: 1'b0, rd: 1'b1, code: code, data: 16'h0000};
        @(negedge CLK_SYS);
        HOST_REQ = '0;
        ok = RD_VALID;
        d = RD_DATA;
        // A memory or processor fault marks the device as untrustworthy.
        if (code == CMD_CML_STATUS && (d[3] || d[4])) fatal_seen = 1'b1;
    endtask : get
endmodule : host_model
`default_nettype wire

/* File: dv/telemetry_bank_tb.sv */
// Testbench of the status and telemetry register bank.
`timescale 1ns/1ps
`default_nettype none
module telemetry_bank_tb;
    import telemetry_bank_pkg::*;
    localparam logic [15:0] SEL_OK = 16'h177b;
    logic        clk_sys, rst_n, meas_valid, startup_done, ecc_corrected, nvm_bulk_read, adc_cur_busy;
    logic        rd_valid, alert_evt, peak_cleared;
    logic [15:0] meas_vin, meas_iout, meas_tdie, meas_freq, meas_pout, rd_data, status_word_hi, e;
    logic [7:0]  adc_sel;
    host_req_t   host_req;
    chan_meas_t  meas_ch [2];
    dev_flags_t  dev_flags;
    int          n_mismatch, n_compared, n_alert, n_clr, cycles, a0;
    telemetry_bank i_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .HOST_REQ(host_req), .MEAS_VALID(meas_valid),
        .MEAS_VIN(meas_vin), .MEAS_IOUT(meas_iout), .MEAS_TDIE(meas_tdie), .MEAS_FREQ(meas_freq),
        .MEAS_POUT(meas_pout), .MEAS_CH(meas_ch), .DEV_FLAGS(dev_flags), .STARTUP_DONE(startup_done),
        .ADC_CUR_BUSY(adc_cur_busy), .ECC_CORRECTED(ecc_corrected), .NVM_BULK_READ(nvm_bulk_read), .RD_DATA(rd_data),
        .RD_VALID(rd_valid), .ALERT_EVT(alert_evt), .ADC_SEL(adc_sel), .STATUS_WORD_HI(status_word_hi),
        .PEAK_CLEARED(peak_cleared));
    host_model i_host (.CLK_SYS(clk_sys), .HOST_REQ(host_req), .RD_DATA(rd_data), .RD_VALID(rd_valid));
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (alert_evt === 1'b1) n_alert++;
        if (peak_cleared === 1'b1) n_clr++;
        if (cycles == 20000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        logic        ok;
        logic [15:0] d;
        i_host.get(code, ok, d);
        check({15'h0, ok}, 16'h0001);
        check(d, exp);
    endtask : rd
    task automatic pulse(input logic [7:0] c, input logic [7:0] v, input logic m, input logic b);
        @(negedge clk_sys);
        dev_flags.cml_evt = c;
        dev_flags.vnd_evt = v;
        meas_valid = m;
        nvm_bulk_read = b;
        @(negedge clk_sys);
        dev_flags.cml_evt = 8'h00;
        dev_flags.vnd_evt = 8'h00;
        meas_valid = 1'b0;
        nvm_bulk_read = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask : pulse
    task automatic set_meas(input logic [15:0] b);
        meas_vin = b + 16'h0101;
        meas_iout = b + 16'h0102;
        meas_tdie = b + 16'h0103;
        for (int c = 0; c < 2; c++) begin
            meas_ch[c] = '{16'h1010 + b + 16'(c), 16'h1020 + b + 16'(c), 16'h1030 + b + 16'(c), 16'h1040 + 16'(c)};
        end
    endtask : set_meas
    task automatic test_done;
        $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    initial begin
        {clk_sys, rst_n, meas_valid, startup_done, nvm_bulk_read, adc_cur_busy} = '0;
        {n_mismatch, n_compared, n_alert, n_clr, cycles} = '0;
        ecc_corrected = 1'b1;
        meas_freq = 16'h1104;
        meas_pout = 16'h1105;
        set_meas(16'h1000);
        dev_flags = '{8'h00, 8'h00, 16'hc6a5, 8'hcf};
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        // --------
        // Memory info, pins and common flags
        // --------
        rd(CMD_MEM_INFO, 16'h0000);
        ecc_corrected = 1'b0;
        rd(CMD_MEM_INFO, 16'h0000);
        pulse(8'h00, 8'h00, 1'b0, 1'b1);
        rd(CMD_MEM_INFO, 16'h0020);
        ecc_corrected = 1'b1;
        i_host.send(CMD_RESTORE, 16'h0000);
        rd(CMD_MEM_INFO, 16'h0000);
        rd(CMD_PINS, 16'hcea5);
        rd(CMD_COMMON, 16'h00cb);
        startup_done = 1'b1;
        repeat (3) @(negedge clk_sys);
        rd(CMD_PINS, 16'hc6a5);
        i_host.send(CMD_PINS, 16'hffff);
        dev_flags.pins = 16'h315a;
        adc_cur_busy = 1'b1;
        repeat (3) @(negedge clk_sys);
        rd(CMD_PINS, 16'h095a);
        // --------
        // Status bytes
        // --------
        a0 = n_alert;
        pulse(8'hff, 8'h00, 1'b0, 1'b0);
        check(16'(n_alert - a0), 16'h0001);
        e = 16'h00fb;
        rd(CMD_CML_STATUS, e);
        check({15'h0, i_host.fatal_seen}, 16'h0001);
        for (int i = 7; i >= 0; i--) begin
            e[i] = 1'b0;
            i_host.send(CMD_CML_STATUS, 16'h0001 << i);
            rd(CMD_CML_STATUS, e);
        end
        a0 = n_alert;
        pulse(8'h00, 8'hff, 1'b0, 1'b0);
        check({15'h0, n_alert != a0}, 16'h0001);
        rd(CMD_VENDOR_STAT, 16'h00fd);
        check(status_word_hi, 16'h1000);
        rd(CMD_STATUS_WORD, 16'h1000);
        i_host.send(CMD_VENDOR_STAT, 16'h00ff);
        rd(CMD_VENDOR_STAT, 16'h0008);
        check(status_word_hi, 16'h1000);
        i_host.send(CMD_FLOG_ERASE, 16'h0000);
        rd(CMD_VENDOR_STAT, 16'h0000);
        check(status_word_hi, 16'h0000);
        // --------
        // Fast selector
        // --------
        rd(CMD_ADC_SEL, 16'h0000);
        for (int v = 0; v < 16; v++) begin
            i_host.send(CMD_ADC_SEL, 16'(v));
            @(negedge clk_sys);
            check({8'h00, adc_sel}, SEL_OK[v] ? 16'(v) : 16'h0004);
            if (SEL_OK[v]) rd(CMD_ADC_SEL, 16'(v));
        end
        i_host.send(CMD_CML_STATUS, 16'h0001);
        rd(CMD_CML_STATUS, 16'h0001);
        i_host.send(CMD_ADC_SEL, 16'h0000);
        i_host.send(CMD_CML_STATUS, 16'h0001);
        rd(CMD_CML_STATUS, 16'h0000);
        // --------
        // Telemetry, paging and peaks
        // --------
        pulse(8'h00, 8'h00, 1'b1, 1'b0);
        set_meas(16'h0000);
        pulse(8'h00, 8'h00, 1'b1, 1'b0);
        i_host.send(CMD_PAGE, 16'h0001);
        rd(CMD_VIN, 16'h0101);
        rd(CMD_IOUT, 16'h0102);
        rd(CMD_TEMP_DIE, 16'h0103);
        rd(CMD_FREQ, 16'h1104);
        rd(CMD_POUT, 16'h1105);
        rd(CMD_IOUT_PK, 16'h1102);
        rd(CMD_VIN_PK, 16'h1101);
        rd(CMD_TDIE_PK, 16'h1103);
        for (int p = 0; p < 2; p++) begin
            i_host.send(CMD_PAGE, 16'(p));
            rd(CMD_IIN, 16'h1010 + 16'(p));
            rd(CMD_VOUT, 16'h1020 + 16'(p));
            rd(CMD_TEMP_EXT, 16'h1030 + 16'(p));
            rd(CMD_PIN_PWR, 16'h1040 + 16'(p));
            rd(CMD_VOUT_PK, 16'h2020 + 16'(p));
            rd(CMD_TEXT_PK, 16'h2030 + 16'(p));
            rd(CMD_IIN_PK, 16'h2010 + 16'(p));
        end
        for (int k = 0; k < 2; k++) begin
            pulse(8'h00, 8'h00, 1'b1, 1'b0);
            a0 = n_clr;
            i_host.send(k == 0 ? CMD_PEAK_CLR : CMD_DEV_RESET, 16'h0000);
            repeat (2) @(negedge clk_sys);
            check(16'(n_clr - a0), 16'h0001);
            rd(CMD_VIN_PK, 16'h0000);
            rd(CMD_VOUT_PK, 16'h0000);
        end
        test_done();
    end
endmodule : telemetry_bank_tb
`default_nettype wire
